// ---- gdfs_regs.svh ----
// constants of the gate driver fault supervisor: offsets, fields, timing
// assumes a 50 MHz clock and an 8-bit register port with 4-bit address
`ifndef GDFS_REGS_SVH
`define GDFS_REGS_SVH

// register offsets
`define GDFS_A_FAULT 4'h0
`define GDFS_A_GSTAT 4'h1
`define GDFS_A_CFG1  4'h2
`define GDFS_A_CFG2  4'h3
`define GDFS_A_CFG3  4'h4
`define GDFS_A_CFG4  4'h5
`define GDFS_A_CMD   4'h6

// field positions
`define GDFS_CMD_CLR  0
`define GDFS_CMD_WDR  1
`define GDFS_C1_REC   2
`define GDFS_C1_OVSEL 3
`define GDFS_C1_CAL   5
`define GDFS_C2_GAIN  1:0
`define GDFS_C2_MUX   2
`define GDFS_C2_CCP   6:4
`define GDFS_C3_THR   5:0
`define GDFS_C3_MODE  6
`define GDFS_C4_TRIP  1:0

// reset value of every configuration register
`define GDFS_CFG_RST 8'h00

// timing
`define GDFS_CLK_MHZ  50
`define GDFS_FILT_US  64
`define GDFS_FILT_CYC (`GDFS_FILT_US * `GDFS_CLK_MHZ)
`define GDFS_DS_US    6
`define GDFS_DS_CYC   (`GDFS_DS_US * `GDFS_CLK_MHZ)
`define GDFS_HOLD_US  32
`define GDFS_HOLD_CYC (`GDFS_HOLD_US * `GDFS_CLK_MHZ)
`define GDFS_WD_MS    60
`define GDFS_WD_CYC   (`GDFS_WD_MS * 1000 * `GDFS_CLK_MHZ)
`define GDFS_CCP_NS   250
`define GDFS_CCP_CYC  ((`GDFS_CCP_NS * `GDFS_CLK_MHZ + 999) / 1000)

`endif

// ---- gdfs_pkg.sv ----
// types shared by the fault supervisor modules
// assumes nothing beyond a SystemVerilog compiler
package gdfs_pkg;

  // state of one gate driver output stage
  typedef enum logic [1:0] {GDFS_SINK, GDFS_SOURCE, GDFS_RLOW} gdfs_drv_t;

  // raw comparator and control pins, all asynchronous to clk
  typedef struct packed {
    logic       en;        // enable, low means standby
    logic       ov_hi;     // supply above upper overvoltage level
    logic       ov_lo;     // supply above lower overvoltage level
    logic       uv;        // supply below undervoltage level
    logic       pump_low;  // pump output below its low level
    logic       temp_warn; // junction above warning level
    logic       temp_sd;   // junction above shutdown level (hysteresis)
    logic       ext_below; // sensor_or_shutoff_input below threshold
    logic [3:0] ds_over;   // drain-source drop above trip level
    logic       dir;       // direction
    logic       pwm;       // pwm
  } gdfs_pins_t;

  // latched fault flags
  typedef struct packed {
    logic       ov;
    logic       uv;
    logic       tw;
    logic       thermal_shutdown_flag;
    logic       guard_timeout_flag;
    logic       pump;
    logic       ext;
    logic [3:0] ds;
  } gdfs_flags_t;

endpackage

// ---- gdfs_filter.sv ----
// one qualification filter: condition must hold limit+1 cycles in a row
// assumes cond is already synchronous to clk
`timescale 1ns/1ps
module gdfs_filter
  import gdfs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] limit,
  input  wire logic        cond,
  output logic             valid
);

  logic [11:0] cnt_q; // cycles the condition has held

  // any gap restarts the count, so glitches never qualify
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 12'h000;
    end else if (!cond) begin
      cnt_q <= 12'h000;
    end else if (cnt_q != limit) begin
      cnt_q <= cnt_q + 12'h001;
    end
  end

  assign valid = cond && (cnt_q == limit);

  fil_held_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(valid) |-> $past(cond, 8))
    else $error("filter passed a condition held under 8 cycles");

endmodule

// ---- gdfs_top.sv ----
// fault supervision and protection sequencing of a four driver H-bridge
// assumes pins arrive asynchronously, register port is on clk
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "gdfs_regs.svh"
module gdfs_top
  import gdfs_pkg::*;
#(
  parameter int WD_CYC = `GDFS_WD_CYC
)
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire gdfs_pins_t        pins,
  input  wire logic              spi_stuck,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  output gdfs_drv_t [3:0]        gate_drv,
  output logic                   pump_en,
  output logic                   ov_thresh_sel,
  output logic      [1:0]        drain_trip_level,
  output logic      [5:0]        external_threshold_code,
  output logic                   sense_sel,
  output logic      [1:0]        sense_gain,
  output logic                   sense_cal
);

  int unsigned WD_LAST;
  assign WD_LAST = WD_CYC - 1;

  // reset and pin synchronisers
  logic       rst_s1_q;   // first reset stage
  logic       rst_i;      // released reset
  gdfs_pins_t pin_s1_q;   // first pin stage, read only by pin_s
  gdfs_pins_t pin_s;      // synchronised pins

  // configuration and status
  logic [7:0]  cfg1_q;    // recovery, ov select, calibration
  logic [7:0]  cfg2_q;    // gain, mux, dead time
  logic [7:0]  cfg3_q;    // threshold code, sensor mode
  logic [7:0]  cfg4_q;    // drain trip level
  gdfs_flags_t flg_q;     // latched flags
  gdfs_flags_t set_v;     // filtered set terms
  gdfs_flags_t keep_v;    // bits surviving this cycle
  logic        stuck_q;   // stuck_reset_flag, set at power-on
  logic        clr;       // status clear command
  logic        wdr;       // watchdog restart command

  // filtered conditions
  logic        ov_f;
  logic        uv_f;
  logic        tw_f;
  logic        tsd_f;
  logic        pump_f;
  logic        ext_f;
  logic [3:0]  ds_f;
  logic [3:0]  ds_cond;   // monitor gated by driver sourcing
  logic        ext_now;   // external overtemp as reported
  logic        sens_mode; // sensor_mode_select

  // watchdog
  logic [21:0] wd_cnt_q;
  logic        wd_hit;

  // driver sequencing
  logic        rl_all;    // resistive low demanded
  logic        sink_all;  // all drivers to sink
  logic [1:0]  hb_sink;   // per half bridge overload
  logic [3:0]  dem;       // drivers demanded by dir/pwm
  logic [3:0]  force_off; // fault overrides per driver
  logic [3:0]  on_q;      // driver through its dead time
  logic [6:0]  ccp_q [4]; // dead time counters
  logic [6:0]  ccp_lim;   // programmed dead time in cycles
  logic [10:0] rl_cnt_q;  // sink hold before resistive low
  logic        rl_done;
  gdfs_drv_t [3:0] gate_d;

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_i    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_i    <= rst_s1_q;
    end
  end

  // pins pass two flops before any logic sees them
  always_ff @(posedge clk or negedge rst_i) begin
    if (!rst_i) begin
      pin_s1_q <= '0;
      pin_s    <= '0;
    end else begin
      pin_s1_q <= pins;
      pin_s    <= pin_s1_q;
    end
  end

  assign clr = reg_wr && (reg_addr == `GDFS_A_CMD)
               && reg_wdata[`GDFS_CMD_CLR];
  assign wdr = reg_wr && (reg_addr == `GDFS_A_CMD)
               && reg_wdata[`GDFS_CMD_WDR];

  // configuration writes; standby wipes the latched setup too
  always_ff @(posedge clk or negedge rst_i) begin
    if (!rst_i) begin
      cfg1_q <= `GDFS_CFG_RST;
      cfg2_q <= `GDFS_CFG_RST;
      cfg3_q <= `GDFS_CFG_RST;
      cfg4_q <= `GDFS_CFG_RST;
    end else if (!pin_s.en) begin
      cfg1_q <= `GDFS_CFG_RST;
      cfg2_q <= `GDFS_CFG_RST;
      cfg3_q <= `GDFS_CFG_RST;
      cfg4_q <= `GDFS_CFG_RST;
    end else if (reg_wr) begin
      if (reg_addr == `GDFS_A_CFG1) begin
        cfg1_q <= reg_wdata;
      end else if (reg_addr == `GDFS_A_CFG2) begin
        cfg2_q <= reg_wdata;
      end else if (reg_addr == `GDFS_A_CFG3) begin
        cfg3_q <= reg_wdata;
      end else if (reg_addr == `GDFS_A_CFG4) begin
        cfg4_q <= reg_wdata;
      end
    end
  end

  // analog setup straight from the registers
  assign ov_thresh_sel    = cfg1_q[`GDFS_C1_OVSEL];
  assign sense_cal        = cfg1_q[`GDFS_C1_CAL];
  assign sense_gain       = cfg2_q[`GDFS_C2_GAIN];
  assign sense_sel        = cfg2_q[`GDFS_C2_MUX];
  assign drain_trip_level = cfg4_q[`GDFS_C4_TRIP];
  assign external_threshold_code = cfg3_q[`GDFS_C3_THR];
  assign sens_mode        = cfg3_q[`GDFS_C3_MODE];

  // qualification filters on every diagnostic condition
  gdfs_filter u_ov (
    .clk   (clk),
    .rst_n (rst_i),
    .limit (12'(`GDFS_FILT_CYC)),
    .cond  (ov_thresh_sel ? pin_s.ov_hi : pin_s.ov_lo),
    .valid (ov_f)
  );
  gdfs_filter u_uv (
    .clk   (clk),
    .rst_n (rst_i),
    .limit (12'(`GDFS_FILT_CYC)),
    .cond  (pin_s.uv),
    .valid (uv_f)
  );
  gdfs_filter u_tw (
    .clk   (clk),
    .rst_n (rst_i),
    .limit (12'(`GDFS_FILT_CYC)),
    .cond  (pin_s.temp_warn),
    .valid (tw_f)
  );
  gdfs_filter u_tsd (
    .clk   (clk),
    .rst_n (rst_i),
    .limit (12'(`GDFS_FILT_CYC)),
    .cond  (pin_s.temp_sd),
    .valid (tsd_f)
  );
  // pump filter time reuses the common qualification length
  gdfs_filter u_pump (
    .clk   (clk),
    .rst_n (rst_i),
    .limit (12'(`GDFS_FILT_CYC)),
    .cond  (pin_s.pump_low),
    .valid (pump_f)
  );
  gdfs_filter u_ext (
    .clk   (clk),
    .rst_n (rst_i),
    .limit (12'(`GDFS_FILT_CYC)),
    .cond  (pin_s.ext_below && sens_mode),
    .valid (ext_f)
  );

  // drain monitor counts only while the stage sources
  for (genvar g = 0; g < 4; g++) begin : g_ds
    assign ds_cond[g] = pin_s.ds_over[g]
                        && (gate_drv[g] == GDFS_SOURCE);
    gdfs_filter u_ds (
      .clk   (clk),
      .rst_n (rst_i),
      .limit (12'(`GDFS_DS_CYC)),
      .cond  (ds_cond[g]),
      .valid (ds_f[g])
    );
  end

  // watchdog: software restarts, a miss sets the timeout
  always_ff @(posedge clk or negedge rst_i) begin
    if (!rst_i) begin
      wd_cnt_q <= 22'h00_0000;
    end else if (!pin_s.en || wdr || flg_q.guard_timeout_flag) begin
      wd_cnt_q <= 22'h00_0000;
    end else begin
      wd_cnt_q <= wd_cnt_q + 22'h00_0001;
    end
  end
  assign wd_hit = (32'(wd_cnt_q) == WD_LAST) && pin_s.en;

  // set terms and what a clear leaves behind
  always_comb begin
    set_v      = '0;
    set_v.ov   = ov_f;
    set_v.uv   = uv_f;
    set_v.tw   = tw_f;
    set_v.thermal_shutdown_flag  = tsd_f;
    set_v.guard_timeout_flag = wd_hit;
    set_v.pump = pump_f;
    set_v.ext  = ext_f;
    set_v.ds   = ds_f;
    keep_v     = clr ? '0 : flg_q;
    if (!sens_mode) begin
      keep_v.ext = 1'b0; // active-off never latches
    end
  end

  // flags: set wins over clear, so live faults survive a clear
  always_ff @(posedge clk or negedge rst_i) begin
    if (!rst_i) begin
      flg_q <= '0;
    end else if (!pin_s.en) begin
      flg_q <= '0;
    end else begin
      flg_q <= keep_v | set_v;
    end
  end

  // stuck flag: up at power-on or stuck input, down on any write
  always_ff @(posedge clk or negedge rst_i) begin
    if (!rst_i) begin
      stuck_q <= 1'b1;
    end else if (spi_stuck) begin
      stuck_q <= 1'b1;
    end else if (reg_wr) begin
      stuck_q <= 1'b0;
    end
  end

  // active-off follows the pin with no filter and no latch
  assign ext_now = sens_mode ? flg_q.ext : pin_s.ext_below;

  // pump: supply faults stop it; recovery bit picks the restart
  always_ff @(posedge clk or negedge rst_i) begin
    if (!rst_i) begin
      pump_en <= 1'b0;
    end else if (!pin_s.en || flg_q.thermal_shutdown_flag) begin
      pump_en <= 1'b0;
    end else if (cfg1_q[`GDFS_C1_REC]) begin
      pump_en <= !(flg_q.ov || flg_q.uv);
    end else begin
      pump_en <= !(ov_f || uv_f);
    end
  end

  // protective demands; temperature warning deliberately absent
  assign rl_all   = !pin_s.en || flg_q.thermal_shutdown_flag || flg_q.pump
                    || stuck_q;
  assign sink_all = ext_now || flg_q.guard_timeout_flag || flg_q.ov
                    || flg_q.uv;
  assign hb_sink  = {|flg_q.ds[3:2], |flg_q.ds[1:0]};
  assign rl_done  = (rl_cnt_q == 11'(`GDFS_HOLD_CYC));

  // sink hold before resistive low; power-on starts already done
  always_ff @(posedge clk or negedge rst_i) begin
    if (!rst_i) begin
      rl_cnt_q <= 11'(`GDFS_HOLD_CYC);
    end else if (!rl_all) begin
      rl_cnt_q <= 11'h000;
    end else if (!rl_done) begin
      rl_cnt_q <= rl_cnt_q + 11'h001;
    end
  end

  // bits: 0 high 1, 1 low 1, 2 high 2, 3 low 2; active low freewheel
  assign dem = pin_s.pwm ? (pin_s.dir ? 4'b1001 : 4'b0110) : 4'b1010;
  assign ccp_lim = 7'({4'h0, cfg2_q[`GDFS_C2_CCP]}
                      * 7'(`GDFS_CCP_CYC));
  assign force_off = {4{rl_all || sink_all}}
                     | {{2{hb_sink[1]}}, {2{hb_sink[0]}}};

  // dead time: a stage turns on only after its partner is off
  always_ff @(posedge clk or negedge rst_i) begin
    if (!rst_i) begin
      on_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        ccp_q[i] <= 7'h00;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!dem[i] || force_off[i]) begin
          on_q[i]  <= 1'b0;
          ccp_q[i] <= 7'h00;
        end else if (!on_q[i] && !on_q[i ^ 1]) begin
          if (ccp_q[i] >= ccp_lim) begin
            on_q[i] <= 1'b1;
          end else begin
            ccp_q[i] <= ccp_q[i] + 7'h01;
          end
        end
      end
    end
  end

  // final stage state, resistive low over sink over normal
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (rl_all) begin
        gate_d[i] = rl_done ? GDFS_RLOW : GDFS_SINK;
      end else if (force_off[i] || !on_q[i]) begin
        gate_d[i] = GDFS_SINK;
      end else begin
        gate_d[i] = GDFS_SOURCE;
      end
    end
  end

  // registered stage outputs
  always_ff @(posedge clk or negedge rst_i) begin
    if (!rst_i) begin
      gate_drv <= '{default: GDFS_RLOW};
    end else begin
      gate_drv <= gate_d;
    end
  end

  // read port: data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk or negedge rst_i) begin
    if (!rst_i) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == `GDFS_A_FAULT) begin
      reg_rdata <= {flg_q.ds, 2'b00, ext_now, flg_q.pump};
    end else if (reg_addr == `GDFS_A_GSTAT) begin
      reg_rdata <= {(stuck_q | flg_q.thermal_shutdown_flag | flg_q.tw | flg_q.uv
                     | flg_q.ov | flg_q.guard_timeout_flag), 1'b0, stuck_q,
                    flg_q.thermal_shutdown_flag, flg_q.tw, flg_q.uv, flg_q.ov,
                    flg_q.guard_timeout_flag};
    end else if (reg_addr == `GDFS_A_CFG1) begin
      reg_rdata <= cfg1_q;
    end else if (reg_addr == `GDFS_A_CFG2) begin
      reg_rdata <= cfg2_q;
    end else if (reg_addr == `GDFS_A_CFG3) begin
      reg_rdata <= cfg3_q;
    end else if (reg_addr == `GDFS_A_CFG4) begin
      reg_rdata <= cfg4_q;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // checks next to the logic they guard
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_i);

  sequence rl_enter;
    $rose(rl_all);
  endsequence
  sequence all_sink;
    gate_drv == {4{GDFS_SINK}};
  endsequence

  rl_hold_a: assert property (
    rl_enter |=> all_sink [*8])
    else $error("drivers left sink early after resistive entry");
  rl_final_a: assert property (
    (rl_all && rl_done) |=> gate_drv == {4{GDFS_RLOW}})
    else $error("resistive low not reached after hold");
  sink_all_a: assert property (
    (sink_all && !rl_all) |=> all_sink)
    else $error("global fault did not sink all drivers");
  half_sink_a: assert property (
    (flg_q.ds[0] && !rl_all && !sink_all && !hb_sink[1]
     && dem[3] && on_q[3]) |=> gate_drv[0] == GDFS_SINK
     && gate_drv[3] == GDFS_SOURCE)
    else $error("overload affected the wrong half bridge");
  clr_keep_a: assert property (
    (clr && ov_f && pin_s.en) |=> flg_q.ov)
    else $error("clear dropped a live overvoltage");
  tsd_pump_a: assert property (
    $rose(flg_q.thermal_shutdown_flag) |=> !pump_en)
    else $error("pump still on after thermal shutdown");
  wd_to_a: assert property (
    wd_hit |=> flg_q.guard_timeout_flag ##1 all_sink)
    else $error("watchdog miss did not latch and sink");
  ext_off_a: assert property (
    (!sens_mode && pin_s.ext_below && pin_s.en && !rl_all)
     |=> all_sink)
    else $error("active-off input not reflected");
  ds_filt_a: assert property (
    $rose(flg_q.ds[0]) |-> $past(ds_cond[0], 8))
    else $error("drain flag set without qualified short");

endmodule

// ---- gdfs_bridge_model.sv ----
// model of the four external bridge transistors and their drain comparators
// assumes gate_drv comes from the supervisor and short_mask from the bench
`timescale 1ns/1ps
module gdfs_bridge_model
  import gdfs_pkg::*;
(
  input  wire gdfs_drv_t [3:0] gate_drv,
  input  wire logic      [3:0] short_mask,
  output logic           [3:0] ds_over
);
  // an off transistor blocks the supply, so its comparator always trips;
  // the supervisor has to ignore it, an on one trips only when shorted
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ds_over[i] = short_mask[i] | (gate_drv[i] != GDFS_SOURCE);
    end
  end
endmodule

// ---- test_gdfs_top.sv ----
// self-checking bench of the fault supervisor top
// assumes package, header, design and bridge model are compiled first
`timescale 1ns/1ps
`include "gdfs_regs.svh"
module test_gdfs_top
  import gdfs_pkg::*;
;
  localparam int WD    = 4000;   // shortened watchdog period
  localparam int FILT  = 3300;   // 64 us filter plus sync margin
  localparam int LIMIT = 80000;  // cycle ceiling of the whole run
  localparam logic [7:0] CLR    = 8'h03;  // clear plus watchdog restart
  localparam logic [7:0] ALL_RL = {4{GDFS_RLOW}};
  localparam logic [7:0] ALL_SK = {4{GDFS_SINK}};
  localparam logic [7:0] FWD = {GDFS_SOURCE, GDFS_SINK,
                                GDFS_SINK, GDFS_SOURCE};
  localparam logic [7:0] REV = {GDFS_SINK, GDFS_SOURCE,
                                GDFS_SOURCE, GDFS_SINK};
  localparam logic [7:0] SHRT = {GDFS_SOURCE, GDFS_SINK, GDFS_SINK, GDFS_SINK};

  logic            clk;         // 50 MHz
  logic            rst_n;       // bench reset
  logic            spi_stuck;   // stuck frame pulse
  logic            reg_wr;      // register write strobe
  logic            reg_rd;      // register read strobe
  logic      [3:0] reg_addr;    // register address
  logic      [7:0] reg_wdata;   // write data
  logic      [7:0] reg_rdata;   // read data
  logic      [7:0] rd;          // last value read
  logic      [3:0] short_mask;  // shorted transistors
  logic      [3:0] ds_over;     // comparators from the model
  gdfs_pins_t      pins_r;      // pins as the bench drives them
  gdfs_pins_t      pins_w;      // pins with the model's comparators
  gdfs_drv_t [3:0] gate_drv;    // driver states
  logic            pump_en;     // charge pump on
  logic            ov_sel;      // overvoltage threshold choice
  logic      [1:0] trip;        // drain trip level
  logic      [5:0] thr;         // external threshold code
  logic            sense_sel;   // shunt choice
  logic      [1:0] gain;        // sense gain code
  logic            sense_cal;   // offset calibration
  int              num_errors;  // mismatches
  int              n_tests;     // comparisons
  int              cyc;         // cycles since start

  // free-running clock, 20 ns period
  initial clk = 1'b0;
  always #10 clk = ~clk;

  gdfs_top #(.WD_CYC(WD)) i_dut (
    .clk(clk), .rst_n(rst_n), .pins(pins_w), .spi_stuck(spi_stuck),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gate_drv(gate_drv),
    .pump_en(pump_en), .ov_thresh_sel(ov_sel), .drain_trip_level(trip),
    .external_threshold_code(thr), .sense_sel(sense_sel),
    .sense_gain(gain), .sense_cal(sense_cal)
  );

  gdfs_bridge_model i_bridge (
    .gate_drv(gate_drv), .short_mask(short_mask), .ds_over(ds_over)
  );

  // comparators come from the model, the rest from the bench
  always_comb begin
    pins_w         = pins_r;
    pins_w.ds_over = ds_over;
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // a hang is counted as a mismatch and ends the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rdr(input logic [3:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  // wait while restarting the watchdog every 500 cycles
  task automatic idle(input int n);
    for (int i = 0; i < n; i += 500) begin
      wr(`GDFS_A_CMD, 8'h02);
      repeat (498) @(posedge clk);
    end
  endtask

  initial begin
    {rst_n, spi_stuck, reg_wr, reg_rd} = '0;
    {reg_addr, reg_wdata, short_mask} = '0;
    {num_errors, n_tests, cyc} = '0;
    pins_r = '0;
    pins_r.en = 1'b1;
    pins_r.dir = 1'b1;
    pins_r.pwm = 1'b1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // stuck flag holds every driver resistive low after reset
    chk("drv_rst", gate_drv, ALL_RL);
    rdr(`GDFS_A_GSTAT);
    chk("gstat_rst", rd & 8'h7f, 8'h20);
    rdr(4'hf);
    chk("unmapped", rd, 8'h00);
    wr(`GDFS_A_CMD, CLR);
    idle(500);
    chk("drv_fwd", gate_drv, FWD);
    chk("pump_on", pump_en, 1'b1);
    // every configuration field reaches its output
    for (int i = 0; i < 4; i++) begin
      wr(`GDFS_A_CFG1, (8'(i[0]) << 3) | (8'(i[1]) << 5));
      wr(`GDFS_A_CFG2, 8'(i % 3) | (8'(i[0]) << 2));
      wr(`GDFS_A_CFG3, 8'(i * 21));
      wr(`GDFS_A_CFG4, 8'(i));
      rdr(`GDFS_A_CFG4);
      chk("cfg4", rd, 8'(i));
      chk("ov_sel", ov_sel, 8'(i[0]));
      chk("cal", sense_cal, 8'(i[1]));
      chk("mux", sense_sel, 8'(i[0]));
      chk("gain", gain, 8'(i % 3));
      chk("trip", trip, 8'(i));
      chk("thr", thr, 8'(i * 21));
    end
    wr(`GDFS_A_CFG1, 8'h00);
    wr(`GDFS_A_CFG3, 8'h00);
    // longest dead time: 7 steps of 13 cycles before the turn-on
    wr(`GDFS_A_CFG2, 8'h70);
    pins_r.dir <= 1'b0;
    repeat (60) @(posedge clk);
    chk("dead_wait", gate_drv, ALL_SK);
    repeat (90) @(posedge clk);
    chk("dead_done", gate_drv, REV);
    pins_r.dir <= 1'b1;
    wr(`GDFS_A_CFG2, 8'h00);
    // warning only flags, and not before the filter time
    pins_r.temp_warn <= 1'b1;
    idle(3000);
    rdr(`GDFS_A_GSTAT);
    chk("tw_early", rd & 8'h7f, 8'h00);
    idle(500);
    rdr(`GDFS_A_GSTAT);
    chk("tw", rd & 8'h7f, 8'h08);
    chk("drv_tw", gate_drv, FWD);
    pins_r.temp_warn <= 1'b0;
    // let the released pin pass the synchroniser before clearing
    repeat (4) @(posedge clk);
    wr(`GDFS_A_CMD, CLR);
    // undervoltage in both recovery modes
    for (int r = 0; r < 2; r++) begin
      wr(`GDFS_A_CFG1, 8'(r) << `GDFS_C1_REC);
      pins_r.uv <= 1'b1;
      idle(FILT);
      chk("drv_uv", gate_drv, ALL_SK);
      chk("pump_uv", pump_en, 1'b0);
      wr(`GDFS_A_CMD, CLR);
      rdr(`GDFS_A_GSTAT);
      chk("uv_kept", rd & 8'h7f, 8'h04);
      pins_r.uv <= 1'b0;
      idle(FILT);
      chk("pump_back", pump_en, 8'(r == 0));
      chk("drv_held", gate_drv, ALL_SK);
      wr(`GDFS_A_CMD, CLR);
      idle(500);
      chk("pump_clr", pump_en, 1'b1);
      chk("drv_uv_clr", gate_drv, FWD);
    end
    // only the selected overvoltage level counts; clear while live
    wr(`GDFS_A_CFG1, 8'h08);
    pins_r.ov_lo <= 1'b1;
    idle(FILT);
    chk("ov_lo_masked", gate_drv, FWD);
    pins_r.ov_hi <= 1'b1;
    idle(FILT);
    chk("drv_ov", gate_drv, ALL_SK);
    wr(`GDFS_A_CMD, CLR);
    rdr(`GDFS_A_GSTAT);
    chk("ov_kept", rd & 8'h7f, 8'h02);
    chk("pump_ov", pump_en, 1'b0);
    pins_r.ov_hi <= 1'b0;
    pins_r.ov_lo <= 1'b0;
    repeat (4) @(posedge clk);
    wr(`GDFS_A_CMD, CLR);
    wr(`GDFS_A_CFG1, 8'h00);
    idle(500);
    chk("drv_ov_clr", gate_drv, FWD);
    chk("pump_ov_clr", pump_en, 1'b1);
    // pump low, then thermal shutdown: sink first, then resistive low
    for (int k = 0; k < 2; k++) begin
      if (k == 0) pins_r.pump_low <= 1'b1;
      else pins_r.temp_sd <= 1'b1;
      idle(4500);
      chk("drv_hold", gate_drv, ALL_SK);
      idle(2500);
      chk("drv_rl", gate_drv, ALL_RL);
      rdr(k ? `GDFS_A_GSTAT : `GDFS_A_FAULT);
      chk("rl_flag", rd & 8'h7f, k ? 8'h10 : 8'h01);
      if (k == 1) chk("pump_tsd", pump_en, 1'b0);
      pins_r.pump_low <= 1'b0;
      pins_r.temp_sd <= 1'b0;
      // a clear racing the synchroniser would find the fault still live
      repeat (4) @(posedge clk);
      wr(`GDFS_A_CMD, CLR);
      idle(500);
      chk("drv_rl_clr", gate_drv, FWD);
    end
    // short on the first high side sinks only its half bridge
    short_mask <= 4'h1;
    idle(500);
    chk("drv_short", gate_drv, SHRT);
    rdr(`GDFS_A_FAULT);
    chk("ds_flag", rd, 8'h10);
    short_mask <= 4'h0;
    idle(500);
    chk("drv_short_kept", gate_drv, SHRT);
    wr(`GDFS_A_CMD, CLR);
    idle(500);
    chk("drv_short_clr", gate_drv, FWD);
    rdr(`GDFS_A_FAULT);
    chk("ds_off_ignored", rd, 8'h00);
    // active-off input acts at once and is not latched
    pins_r.ext_below <= 1'b1;
    repeat (8) @(posedge clk);
    chk("act_off", gate_drv, ALL_SK);
    rdr(`GDFS_A_FAULT);
    chk("ext_flag", rd, 8'h02);
    pins_r.ext_below <= 1'b0;
    idle(500);
    chk("act_on", gate_drv, FWD);
    rdr(`GDFS_A_FAULT);
    chk("ext_gone", rd, 8'h00);
    // sensor mode filters and latches
    wr(`GDFS_A_CFG3, 8'h40);
    pins_r.ext_below <= 1'b1;
    idle(FILT);
    pins_r.ext_below <= 1'b0;
    idle(500);
    chk("sens_sink", gate_drv, ALL_SK);
    rdr(`GDFS_A_FAULT);
    chk("sens_flag", rd, 8'h02);
    wr(`GDFS_A_CMD, CLR);
    idle(500);
    chk("sens_clr", gate_drv, FWD);
    wr(`GDFS_A_CFG3, 8'h00);
    // missed watchdog restart
    repeat (WD + 100) @(posedge clk);
    rdr(`GDFS_A_GSTAT);
    chk("guard_timeout_flag", rd, 8'h81);
    chk("drv_guard_timeout_flag", gate_drv, ALL_SK);
    wr(`GDFS_A_CMD, CLR);
    idle(500);
    chk("drv_wd_clr", gate_drv, FWD);
    // stuck frame starts the sink-first sequence
    @(posedge clk);
    spi_stuck <= 1'b1;
    @(posedge clk);
    spi_stuck <= 1'b0;
    repeat (10) @(posedge clk);
    chk("drv_stuck", gate_drv, ALL_SK);
    rdr(`GDFS_A_GSTAT);
    chk("stuck", rd & 8'h7f, 8'h20);
    wr(`GDFS_A_CFG4, 8'h03);
    idle(500);
    chk("drv_stuck_clr", gate_drv, FWD);
    // standby wipes configuration, stops pump and drivers
    pins_r.en <= 1'b0;
    repeat (3400) @(posedge clk);
    chk("drv_stby", gate_drv, ALL_RL);
    chk("pump_stby", pump_en, 1'b0);
    rdr(`GDFS_A_CFG4);
    chk("cfg_stby", rd, 8'h00);
    give_verdict();
  end
endmodule
